// *** current_unbalance_protection.sv ***
// current unbalance protection decision logic: start, delayed trip, events
`timescale 1ns/1ps
module current_unbalance_protection #(
   parameter int unsigned MAG_W        = 16,
   parameter int unsigned CYC_PER_STEP = unbalance_pkg::CYC_PER_STEP
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   // phase magnitudes from the measurement stage
   input  wire logic [MAG_W-1:0] mag_l1_i,
   input  wire logic [MAG_W-1:0] mag_l2_i,
   input  wire logic [MAG_W-1:0] mag_l3_i,
   input  wire logic             sample_valid_i,
   input  wire logic [MAG_W-1:0] rated_current_i,
   // settings, captured on settings_load_i
   input  wire logic             settings_load_i,
   input  wire logic             operation_on_i,
   input  wire logic             start_only_i,
   input  wire logic [6:0]       threshold_pct_i,
   input  wire logic [15:0]      delay_ms_i,
   // disable and blocking from surrounding logic
   input  wire logic             disable_i,
   input  wire logic             unbalance_block_in_i,
   // general outputs
   output logic                  unbalance_start_out_o,
   output logic                  unbalance_trip_out_o,
   // events
   output logic                  start_event_o,
   output logic                  start_event_value_o,
   output logic                  trip_event_o,
   output logic                  trip_event_value_o,
   // current settings
   output logic [6:0]            threshold_o,
   output logic [15:0]           delay_o
);
   typedef struct packed {
      logic        oper;
      logic        start_only;
      logic [6:0]  thr;
      logic [15:0] dly;
      logic        start;
      logic        trip;
      logic        st_evt;
      logic        tr_evt;
   } prot_t;

   localparam prot_t RESET_ST = '{
      oper:       1'b0,
      start_only: 1'b0,
      thr:        unbalance_pkg::THR_DEF,
      dly:        unbalance_pkg::DLY_DEF,
      start:      1'b0,
      trip:       1'b0,
      st_evt:     1'b0,
      tr_evt:     1'b0
   };

   prot_t            st_ff;
   prot_t            nxt_st;
   logic [MAG_W-1:0] mx;
   logic [MAG_W-1:0] mn;
   logic [31:0]      diff_scaled;
   logic [31:0]      ref_on;
   logic [31:0]      ref_off;
   logic             level_ok;
   logic             pickup_w;
   logic             keep_w;
   logic             enabled;
   logic             run_w;
   logic             expired_w;

   // largest and smallest phase magnitude
   always_comb
   begin
      mx = mag_l1_i;
      mn = mag_l1_i;
      if (mag_l2_i > mx)
         mx = mag_l2_i;
      if (mag_l3_i > mx)
         mx = mag_l3_i;
      if (mag_l2_i < mn)
         mn = mag_l2_i;
      if (mag_l3_i < mn)
         mn = mag_l3_i;
   end

   // percent compare without division, all scaled by 20 for the 95% ratio
   assign diff_scaled = 32'(mx - mn) * unbalance_pkg::PCT_FULL
                        * unbalance_pkg::HYST_DEN; // RL2
   assign ref_on  = 32'(st_ff.thr) * 32'(mx) * unbalance_pkg::HYST_DEN;
   assign ref_off = 32'(st_ff.thr) * 32'(mx) * unbalance_pkg::HYST_NUM; // RL13

   // max phase within 0.1..1.5 of rated
   assign level_ok = (32'(mx) * unbalance_pkg::LVL_LO_MUL > 32'(rated_current_i))
                  && (32'(mx) * unbalance_pkg::LVL_HI_MUL
                      < 32'(rated_current_i) * unbalance_pkg::LVL_HI_RATED); // RL3

   assign enabled = st_ff.oper && !disable_i; // RL1

   // pickup and hold decisions of the start comparator
   assign pickup_w = level_ok && (diff_scaled > ref_on); // RL2
   assign keep_w   = level_ok && !(diff_scaled < ref_off); // RL13

   // settings capture, start decision, trip and events
   always_comb
   begin
      nxt_st = st_ff;
      if (settings_load_i)
      begin
         nxt_st.oper       = operation_on_i;
         nxt_st.start_only = start_only_i; // RL5
         if (threshold_pct_i < unbalance_pkg::THR_MIN) // RL6
            nxt_st.thr = unbalance_pkg::THR_MIN;
         else if (threshold_pct_i > unbalance_pkg::THR_MAX)
            nxt_st.thr = unbalance_pkg::THR_MAX;
         else
            nxt_st.thr = threshold_pct_i;
         if (delay_ms_i < unbalance_pkg::DLY_MIN) // RL7
            nxt_st.dly = unbalance_pkg::DLY_MIN;
         else if (delay_ms_i > unbalance_pkg::DLY_MAX)
            nxt_st.dly = unbalance_pkg::DLY_MAX;
         else
            nxt_st.dly = delay_ms_i;
      end
      if (!enabled || unbalance_block_in_i)
      begin
         nxt_st.start = 1'b0; // RL1 RL8
      end
      else if (sample_valid_i)
      begin
         if (!st_ff.start)
            nxt_st.start = pickup_w; // RL2 RL9
         else
            nxt_st.start = keep_w; // RL13
      end
      nxt_st.trip   = nxt_st.start && expired_w && !nxt_st.start_only; // RL4 RL5 RL10 RL14
      nxt_st.st_evt = (nxt_st.start != st_ff.start); // RL11
      nxt_st.tr_evt = (nxt_st.trip != st_ff.trip); // RL11
   end

   // timer runs from the same edge that first sees the faulty sample
   assign run_w = nxt_st.start; // RL12 RL14

   unbalance_delay_timer #(
      .CYC_PER_STEP (CYC_PER_STEP),
      .DLY_W        (16)
   ) u_timer (
      .clock_i    (clock_i),
      .rstn_i     (rstn_i),
      .run_i      (run_w),
      .delay_ms_i (st_ff.dly),
      .expired_o  (expired_w)
   );

   // state register
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_ff <= RESET_ST;
      else
         st_ff <= nxt_st;
   end

   // outputs straight from the state register
   assign unbalance_start_out_o = st_ff.start;
   assign unbalance_trip_out_o  = st_ff.trip;
   assign start_event_o         = st_ff.st_evt;
   assign start_event_value_o   = st_ff.start;
   assign trip_event_o          = st_ff.tr_evt;
   assign trip_event_value_o    = st_ff.trip;
   assign threshold_o           = st_ff.thr;
   assign delay_o               = st_ff.dly;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence s_quiet_after;
      ##1 (!unbalance_start_out_o && !unbalance_trip_out_o);
   endsequence

   a_disable_quiet : assert property (!enabled |-> s_quiet_after) // RL1
      else $error("output active while disabled");
   a_block_quiet : assert property (unbalance_block_in_i |-> s_quiet_after) // RL8
      else $error("output active while blocked");
   a_start_only_notrip : assert property (st_ff.start_only |-> !unbalance_trip_out_o) // RL5
      else $error("trip in start-only mode");
   a_trip_needs_start : assert property (unbalance_trip_out_o |-> unbalance_start_out_o) // RL10
      else $error("trip without start");
   a_start_event : assert property ($changed(unbalance_start_out_o) == start_event_o) // RL11
      else $error("start event mismatch");
   a_trip_event : assert property ($changed(unbalance_trip_out_o) == trip_event_o) // RL11
      else $error("trip event mismatch");
   a_start_level : assert property ($rose(unbalance_start_out_o) |-> $past(level_ok)) // RL3
      else $error("start outside level window");
   a_thr_range : assert property (st_ff.thr >= unbalance_pkg::THR_MIN
                                  && st_ff.thr <= unbalance_pkg::THR_MAX) // RL6
      else $error("threshold out of range");
   a_dly_range : assert property (st_ff.dly >= unbalance_pkg::DLY_MIN
                                  && st_ff.dly <= unbalance_pkg::DLY_MAX) // RL7
      else $error("delay out of range");
   a_trip_clear : assert property ($fell(unbalance_start_out_o)
                                   |-> !unbalance_trip_out_o) // RL14
      else $error("trip held after start dropped");
   a_trip_delay : assert property ($rose(unbalance_trip_out_o)
                                   |-> $past(expired_w) && $past(run_w)) // RL4 RL12
      else $error("trip before delay elapsed");

   // a start edge needs a valid sample that met the pickup condition
   sequence s_pickup_seen;
      $past(sample_valid_i) && $past(pickup_w);
   endsequence

   // a start drop needs disable, block or a valid sample below the hold level
   sequence s_drop_seen;
      !$past(enabled) || $past(unbalance_block_in_i)
      || ($past(sample_valid_i) && !$past(keep_w));
   endsequence

   a_pickup_cause : assert property ($rose(unbalance_start_out_o) |-> s_pickup_seen) // RL2
      else $error("start rose without an unbalanced sample");
   a_drop_cause : assert property ($fell(unbalance_start_out_o) |-> s_drop_seen) // RL13
      else $error("start fell without a cause");
   a_start_hold : assert property (enabled && !unbalance_block_in_i && !sample_valid_i // RL9
                                   |=> $stable(unbalance_start_out_o))
      else $error("start moved without a sample");
   a_trip_after_start : assert property ($rose(unbalance_trip_out_o) // RL4
                                         |-> $past(unbalance_start_out_o, 8))
      else $error("trip too soon after start");
endmodule

// *** phase_source.sv ***
// upstream phase magnitude stage model: one sample per bench request
`timescale 1ns/1ps
module phase_source (
   // clock
   input  wire logic        clock_i,
   // request from the bench
   input  wire logic        req_i,
   input  wire logic [15:0] l1_i,
   input  wire logic [15:0] l2_i,
   input  wire logic [15:0] l3_i,
   // magnitudes toward the block
   output logic [15:0]      mag_l1_o,
   output logic [15:0]      mag_l2_o,
   output logic [15:0]      mag_l3_o,
   output logic             sample_valid_o
);
   logic [47:0] held_ff = 48'h0000_0000_0000;
   // remember the last sample so idle lines can show its inverse
   always @(posedge clock_i)
   begin
      if (req_i)
      begin
         held_ff <= {l1_i, l2_i, l3_i};
      end
   end
   // between samples the lines carry stale, inverted data, never a clean copy
   assign {mag_l1_o, mag_l2_o, mag_l3_o} = req_i ? {l1_i, l2_i, l3_i} : ~held_ff;
   assign sample_valid_o = req_i;
endmodule

// *** tb.sv ***
// self-checking bench for the current unbalance protection block
`timescale 1ns/1ps
module tb;
   localparam int unsigned CYC = 4;
   localparam int unsigned TC  = 100 * CYC;
   logic        clock_i, rstn_i, req, valid, load, oper, so, dis, blk;
   logic        st, tr, sev, sval, tev, tval;
   logic [15:0] l1, l2, l3, m1, m2, m3, dly, dly_o, rated;
   logic [6:0]  thr, thr_o;
   int          bad_count, tests_run, cyc, n;

   phase_source src (.clock_i(clock_i), .req_i(req), .l1_i(l1), .l2_i(l2), .l3_i(l3),
      .mag_l1_o(m1), .mag_l2_o(m2), .mag_l3_o(m3), .sample_valid_o(valid));

   current_unbalance_protection #(.MAG_W(16), .CYC_PER_STEP(CYC)) dut (
      .clock_i(clock_i), .rstn_i(rstn_i),
      .mag_l1_i(m1), .mag_l2_i(m2), .mag_l3_i(m3), .sample_valid_i(valid),
      .rated_current_i(rated), .settings_load_i(load), .operation_on_i(oper),
      .start_only_i(so), .threshold_pct_i(thr), .delay_ms_i(dly),
      .disable_i(dis), .unbalance_block_in_i(blk),
      .unbalance_start_out_o(st), .unbalance_trip_out_o(tr),
      .start_event_o(sev), .start_event_value_o(sval),
      .trip_event_o(tev), .trip_event_value_o(tval),
      .threshold_o(thr_o), .delay_o(dly_o));

   // clock and hang guard
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         test_done();
      end
   end

   task automatic test_done;
      if (bad_count == 0 && tests_run > 0)
      begin
         $display("STATUS OK");
      end
      else
      begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // settings load: one pulse, then let the captured values show
   task automatic cfg(input logic s, input logic [6:0] t, input logic [15:0] d);
      @(negedge clock_i);
      {load, oper, so, thr, dly} = {1'b1, 1'b1, s, t, d};
      @(negedge clock_i);
      load = 1'b0;
      @(negedge clock_i);
   endtask

   // one measurement sample through the partner
   task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
      @(negedge clock_i);
      {req, l1, l2, l3} = {1'b1, a, b, c};
      @(negedge clock_i);
      req = 1'b0;
   endtask

   // start must change to exp, marked by a one-cycle event carrying exp
   task automatic wst(input logic exp);
      n = 0;
      while (st !== exp && n < 4)
      begin
         @(negedge clock_i);
         n++;
      end
      chk({st, sev, sval}, {exp, 1'b1, exp});
      @(negedge clock_i);
      chk(sev, 1'b0);
   endtask

   // count cycles from a visible start until trip, then check its event
   task automatic wtr;
      n = 0;
      while (tr !== 1'b1 && n < 500)
      begin
         @(negedge clock_i);
         n++;
      end
      chk(n + 1 >= TC && n <= TC + 2, 1'b1);
      chk({tr, tev, tval}, 3'h7);
   endtask

   initial
   begin
      {rstn_i, req, load, oper, so, dis, blk} = 7'h00;
      {l1, l2, l3, thr, dly} = '0;
      rated = 16'h03e8;
      repeat (5) @(negedge clock_i);
      rstn_i = 1'b1;
      chk({st, tr, thr_o, dly_o}, {2'b00, 7'h32, 16'h03e8});
      smp(16'h01f4, 16'h01f4, 16'h012c);
      repeat (3) @(negedge clock_i);
      chk(st, 1'b0);
      cfg(1'b0, 7'h5f, 16'hfde8);
      chk({thr_o, dly_o}, {7'h5a, 16'hea60});
      cfg(1'b0, 7'h05, 16'h0032);
      chk({thr_o, dly_o}, {7'h0a, 16'h0064});
      cfg(1'b0, 7'h14, 16'h0064);
      // exactly at threshold, then max at 10 % and at 150 % rated: no start
      smp(16'h01f4, 16'h01f4, 16'h0190);
      smp(16'h0064, 16'h0064, 16'h0032);
      smp(16'h05dc, 16'h03e8, 16'h03e8);
      repeat (3) @(negedge clock_i);
      chk(st, 1'b0);
      smp(16'h0065, 16'h0065, 16'h0032);
      wst(1'b1);
      smp(16'h01f4, 16'h01f4, 16'h0193);
      repeat (3) @(negedge clock_i);
      chk(st, 1'b1);
      smp(16'h01f4, 16'h01f4, 16'h019a);
      wst(1'b0);
      smp(16'h01f4, 16'h01f4, 16'h012c);
      wst(1'b1);
      wtr();
      smp(16'h01f4, 16'h01f4, 16'h01e0);
      chk({tr, tev, tval}, 3'h2);
      wst(1'b0);
      chk(tr, 1'b0);
      smp(16'h01f4, 16'h01f4, 16'h012c);
      wst(1'b1);
      repeat (200) @(negedge clock_i);
      blk = 1'b1;
      @(negedge clock_i);
      chk({st, tr}, 2'b00);
      blk = 1'b0;
      smp(16'h01f4, 16'h01f4, 16'h012c);
      wst(1'b1);
      wtr();
      dis = 1'b1;
      @(negedge clock_i);
      chk({st, tr}, 2'b00);
      dis = 1'b0;
      cfg(1'b1, 7'h14, 16'h0064);
      smp(16'h01f4, 16'h01f4, 16'h012c);
      wst(1'b1);
      repeat (TC + 20) @(negedge clock_i);
      chk({st, tr}, 2'b10);
      // rated doubled: a max at 10 % of it leaves the window, start drops
      rated = 16'h07d0;
      smp(16'h00c8, 16'h00c8, 16'h0064);
      wst(1'b0);
      test_done();
   end
endmodule

// *** unbalance_delay_timer.sv ***
// millisecond delay timer with prescaler, cleared whenever run is low
`timescale 1ns/1ps
module unbalance_delay_timer #(
   parameter int unsigned CYC_PER_STEP = unbalance_pkg::CYC_PER_STEP,
   parameter int unsigned DLY_W        = 16
) (
   // clock and reset
   input  wire logic             clock_i,
   input  wire logic             rstn_i,
   // control
   input  wire logic             run_i,
   input  wire logic [DLY_W-1:0] delay_ms_i,
   // status
   output logic                  expired_o
);
   localparam int unsigned PRE_W = $clog2(CYC_PER_STEP + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_STEP - 1);

   typedef struct packed {
      logic [PRE_W-1:0] pre;
      logic [DLY_W-1:0] ms;
   } tmr_t;

   tmr_t st_ff;
   tmr_t nxt_st;

   // elapsed whole steps reached the setting
   assign expired_o = (st_ff.ms >= delay_ms_i);

   // count steps while running, restart from zero otherwise
   always_comb
   begin
      nxt_st = st_ff;
      if (!run_i)
      begin
         nxt_st = '0; // RL14
      end
      else if (!expired_o)
      begin
         if (st_ff.pre == PRE_LAST)
         begin
            nxt_st.pre = '0;
            nxt_st.ms  = st_ff.ms + DLY_W'(1); // RL12
         end
         else
         begin
            nxt_st.pre = st_ff.pre + PRE_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   a_timer_idle : assert property (@(posedge clock_i) disable iff (!rstn_i)
      !run_i |=> st_ff.ms == '0) // RL14
      else $error("timer not cleared after run dropped");
endmodule

// *** unbalance_pkg.sv ***
// constants shared by the current unbalance protection decision block
//
// Contract
// [RL1] both outputs stay inactive while operation is off or external disable is high
// [RL2] unbalance when (max-min) as percent of max phase exceeds threshold
// [RL3] start permitted only while max phase is above 10% and below 150% rated
// [RL4] trip rises only after the configured delay and only when trip is permitted
// [RL5] start-only mode never trips; mode reads false after reset
// [RL6] threshold setting 10..90 percent, step one, default 50
// [RL7] delay setting 100..60000 ms, step one, default 1000, latency included
// [RL8] blocking input forces start and trip inactive; surrounding logic drives it
// [RL9] one general start output, high while qualified unbalance is detected
// [RL10] one general trip output, high when delayed trip condition is met
// [RL11] event pulse on every rise and fall of start and of trip, with new value
// [RL12] delay runs from the first faulty sample, not from start output
// [RL13] hysteresis: started state drops only below 95% of threshold
// [RL14] delay counter and trip clear when start drops, disabled or blocked
package unbalance_pkg;
   // threshold setting, percent
   localparam logic [6:0]  THR_MIN       = 7'h0A;
   localparam logic [6:0]  THR_MAX       = 7'h5A;
   localparam logic [6:0]  THR_DEF       = 7'h32;
   // delay setting, milliseconds
   localparam logic [15:0] DLY_MIN       = 16'h0064;
   localparam logic [15:0] DLY_MAX       = 16'hEA60;
   localparam logic [15:0] DLY_DEF       = 16'h03E8;
   // timing: clock period and delay step, both in ns
   localparam int unsigned CLK_PERIOD_NS = 32'h0000_0019;
   localparam int unsigned STEP_NS       = 32'h000F_4240;
   localparam int unsigned CYC_PER_STEP  = STEP_NS / CLK_PERIOD_NS;
   // percent arithmetic: full scale and hysteresis ratio 19/20
   localparam logic [31:0] PCT_FULL      = 32'h0000_0064;
   localparam logic [31:0] HYST_DEN      = 32'h0000_0014;
   localparam logic [31:0] HYST_NUM      = 32'h0000_0013;
   // level window: max*10 > rated, max*2 < rated*3
   localparam logic [31:0] LVL_LO_MUL    = 32'h0000_000A;
   localparam logic [31:0] LVL_HI_MUL    = 32'h0000_0002;
   localparam logic [31:0] LVL_HI_RATED  = 32'h0000_0003;
endpackage
